//--- logic/gcsm_regs.svh
// timing counts, counter sizes and synchroniser bit positions of the glitchless clock switchover mux
`ifndef GCSM_REGS_SVH
`define GCSM_REGS_SVH

// falling edges of the old clock followed before parking
`define GCSM_DRAIN_PULSES 4'h2
// rising edges of the new clock that end waiting on a stuck old clock
`define GCSM_STUCK_LIMIT 4'h3
// falling edges of the new clock with the output parked low
`define GCSM_PARK_EDGES 4'h2
// longest select-to-output delay, in input clock cycles
`define GCSM_SEL_TO_OUT_MAX 17
// saturation value of the edge counters
`define GCSM_COUNT_MAX 4'hF
// width of the edge counters
`define GCSM_COUNT_W 4
// number of asynchronous inputs passing the synchroniser
`define GCSM_SYNC_W 6
// synchroniser bit positions
`define GCSM_SYNC_A 0
`define GCSM_SYNC_B 1
`define GCSM_SYNC_SEL 2
`define GCSM_SYNC_LOW_A 3
`define GCSM_SYNC_LOW_B 4
`define GCSM_SYNC_STRAP 5

`endif

//--- logic/gcsm_pkg.sv
// types shared by the glitchless clock switchover mux
package gcsm_pkg;

    typedef enum logic [2:0] {
        GCSM_FOLLOW = 3'h1,
        GCSM_DRAIN  = 3'h2,
        GCSM_PARK   = 3'h4
    } gcsm_state_type;

    typedef enum logic {
        GCSM_SRC_A = 1'h0,
        GCSM_SRC_B = 1'h1
    } gcsm_src_type;

endpackage

//--- logic/gcsm_edge_counter.sv
// saturating event counter with synchronous clear
`timescale 1ns/1ns
`include "gcsm_regs.svh"

module gcsm_edge_counter (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic event_i,
    output logic [`GCSM_COUNT_W-1:0] count_o
);

    logic [`GCSM_COUNT_W-1:0] count_ff;

    // clear wins so a fresh stage never inherits an edge of the old one
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || clear_i) begin
            count_ff <= '0;
        end else if (event_i && count_ff != `GCSM_COUNT_MAX) begin
            count_ff <= count_ff + 4'h1;
        end
    end

    assign count_o = count_ff;

endmodule

//--- logic/gcsm_mux.sv
// glitchless two-input clock switchover mux, sampled in the core clock
`timescale 1ns/1ns
`include "gcsm_regs.svh"

module gcsm_mux (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clock_input_a_i,
    input wire logic clock_input_b_i,
    input wire logic select_i,
    input wire logic startup_delay_cap_pin_i,
    input wire logic low_swing_hold_a_i,
    input wire logic low_swing_hold_b_i,
    output logic active_clock_o,
    output gcsm_pkg::gcsm_src_type active_source_o,
    output logic switching_o,
    output logic short_cycle_suppressor_on_o
);
    import gcsm_pkg::*;

    // picks the level of one source; both inputs share this path
    function automatic logic pick_level(input gcsm_src_type src,
                                        input logic lvl_a,
                                        input logic lvl_b);
        pick_level = (src == GCSM_SRC_B) ? lvl_b : lvl_a;
    endfunction

    function automatic logic pick_edge(input gcsm_src_type src,
                                       input logic edge_a,
                                       input logic edge_b);
        pick_edge = (src == GCSM_SRC_B) ? edge_b : edge_a;
    endfunction

    logic [`GCSM_SYNC_W-1:0] meta_ff;
    logic [`GCSM_SYNC_W-1:0] sync_ff;
    logic held_a_ff;
    logic held_b_ff;
    logic prev_a_ff;
    logic prev_b_ff;
    logic supp_en_ff;
    gcsm_state_type state_ff;
    gcsm_state_type nxt_state;
    gcsm_src_type cur_src_ff;
    gcsm_src_type nxt_cur_src;
    logic out_ff;
    logic nxt_out;
    logic switching_ff;
    gcsm_src_type sel_src;
    gcsm_src_type new_src;
    logic rise_a;
    logic rise_b;
    logic fall_a;
    logic fall_b;
    logic old_level;
    logic new_level;
    logic old_fall;
    logic new_rise;
    logic new_fall;
    logic go_park;
    logic go_follow;
    logic clear_old;
    logic clear_new;
    logic event_new;
    logic [`GCSM_COUNT_W-1:0] old_cnt;
    logic [`GCSM_COUNT_W-1:0] new_cnt;

    // every pin but the reset is asynchronous to the core clock; the first stage feeds
    // only the second so no logic ever sees a metastable level
    always_ff @(posedge core_clk_i) begin
        meta_ff <= {startup_delay_cap_pin_i, low_swing_hold_b_i,
                    low_swing_hold_a_i, select_i,
                    clock_input_b_i, clock_input_a_i};
        sync_ff <= meta_ff;
    end

    // last valid level of each input, frozen while its swing is too low
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            held_a_ff <= 1'h0;
            held_b_ff <= 1'h0;
        end else begin
            if (!sync_ff[`GCSM_SYNC_LOW_A]) begin
                held_a_ff <= sync_ff[`GCSM_SYNC_A];
            end
            if (!sync_ff[`GCSM_SYNC_LOW_B]) begin
                held_b_ff <= sync_ff[`GCSM_SYNC_B];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prev_a_ff <= 1'h0;
            prev_b_ff <= 1'h0;
        end else begin
            prev_a_ff <= held_a_ff;
            prev_b_ff <= held_b_ff;
        end
    end

    assign rise_a = held_a_ff & ~prev_a_ff;
    assign rise_b = held_b_ff & ~prev_b_ff;
    assign fall_a = ~held_a_ff & prev_a_ff;
    assign fall_b = ~held_b_ff & prev_b_ff;

    // the strap is caught while reset is held; the reset must therefore
    // last at least three core clock edges to fill the synchroniser
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            supp_en_ff <= ~sync_ff[`GCSM_SYNC_STRAP];
        end
    end

    assign sel_src = sync_ff[`GCSM_SYNC_SEL] ? GCSM_SRC_B : GCSM_SRC_A;
    assign new_src = (cur_src_ff == GCSM_SRC_A) ? GCSM_SRC_B : GCSM_SRC_A;
    assign old_level = pick_level(cur_src_ff, held_a_ff, held_b_ff);
    assign new_level = pick_level(new_src, held_a_ff, held_b_ff);
    assign old_fall = pick_edge(cur_src_ff, fall_a, fall_b);
    assign new_rise = pick_edge(new_src, rise_a, rise_b);
    assign new_fall = pick_edge(new_src, fall_a, fall_b);

    // leave the old clock on its own falling edge, or, when it is stuck,
    // on a falling edge of the new one so the last high pulse is long
    assign go_park = (state_ff == GCSM_DRAIN) &&
        ((old_fall && old_cnt == `GCSM_DRAIN_PULSES - 4'h1) ||
         (new_fall && new_cnt >= `GCSM_STUCK_LIMIT));
    // hand over right after a new falling edge, while the new clock is low
    assign go_follow = (state_ff == GCSM_PARK) && new_fall &&
        (new_cnt == `GCSM_PARK_EDGES - 4'h1);

    assign clear_old = (state_ff == GCSM_FOLLOW);
    assign clear_new = (state_ff == GCSM_FOLLOW) || go_park;
    assign event_new = (state_ff == GCSM_DRAIN) ? new_rise :
                       (state_ff == GCSM_PARK) ? new_fall : 1'h0;

    gcsm_edge_counter u_old_counter (
        .core_clk_i (core_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i (clear_old),
        .event_i (old_fall && state_ff == GCSM_DRAIN),
        .count_o (old_cnt)
    );

    gcsm_edge_counter u_new_counter (
        .core_clk_i (core_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i (clear_new),
        .event_i (event_new),
        .count_o (new_cnt)
    );

    // handover sequencing and output level
    always_comb begin
        nxt_state = state_ff;
        nxt_cur_src = cur_src_ff;
        nxt_out = old_level;
        case (state_ff)
            GCSM_FOLLOW: begin
                if (sel_src != cur_src_ff) begin
                    if (supp_en_ff) begin
                        nxt_state = GCSM_DRAIN;
                    end else begin
                        nxt_cur_src = sel_src;
                        nxt_out = pick_level(sel_src, held_a_ff,
                                             held_b_ff);
                    end
                end
            end
            GCSM_DRAIN: begin
                if (go_park) begin
                    nxt_state = GCSM_PARK;
                    nxt_out = 1'h0;
                end else begin
                    nxt_out = old_level;
                end
            end
            GCSM_PARK: begin
                if (go_follow) begin
                    nxt_state = GCSM_FOLLOW;
                    nxt_cur_src = new_src;
                    nxt_out = new_level;
                end else begin
                    nxt_out = 1'h0;
                end
            end
            default: begin
                nxt_state = GCSM_FOLLOW;
                nxt_out = 1'h0;
            end
        endcase
    end

    // a select change during a handover is seen only once it completes,
    // which keeps each handover whole at the cost of some extra latency
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= GCSM_FOLLOW;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the source already selected at reset is taken without a handover
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cur_src_ff <= sel_src;
        end else begin
            cur_src_ff <= nxt_cur_src;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            out_ff <= 1'h0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            switching_ff <= 1'h0;
        end else begin
            switching_ff <= (nxt_state != GCSM_FOLLOW);
        end
    end

    assign active_clock_o = out_ff;
    assign active_source_o = cur_src_ff;
    assign switching_o = switching_ff;
    assign short_cycle_suppressor_on_o = supp_en_ff;

endmodule

//--- testbench/gcsm_mux_props.sv
// port assertions for the glitchless clock switchover mux
`timescale 1ns/1ns

module gcsm_mux_props (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic select_i,
    input wire logic low_swing_hold_a_i,
    input wire logic low_swing_hold_b_i,
    input wire logic active_clock_o,
    input wire gcsm_pkg::gcsm_src_type active_source_o,
    input wire logic switching_o,
    input wire logic short_cycle_suppressor_on_o
);
    import gcsm_pkg::*;
    // 17 periods of the faster bench source (174 ns), in core cycles
    localparam int SEL_BOUND = 147;
    logic [3:0] settle_ff;
    wire sup_on = short_cycle_suppressor_on_o;
    // the first pulse after reset may be cut by the reset itself
    wire settled = settle_ff == 4'hF;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            settle_ff <= 4'h0;
        end else if (!settled) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    high_pulse_a: assert property (
        sup_on && settled && $rose(active_clock_o) |-> active_clock_o[*3])
        else $error("short high pulse");
    low_pulse_a: assert property (
        sup_on && settled && $fell(active_clock_o) |-> !active_clock_o[*3])
        else $error("short low pulse");
    source_at_end_a: assert property (
        sup_on && $changed(active_source_o) |-> $fell(switching_o))
        else $error("source moved outside handover end");
    plain_mux_a: assert property (
        !sup_on |-> !switching_o)
        else $error("handover with suppression off");
    direct_route_a: assert property (
        (!sup_on && $stable(select_i))[*5] |-> active_source_o == select_i)
        else $error("source does not match select");
    sel_bound_a: assert property (
        sup_on && settled && $changed(select_i) && !switching_o
        |-> ##[1:SEL_BOUND] active_source_o == select_i)
        else $error("handover too slow");
    swing_hold_a_a: assert property (
        (low_swing_hold_a_i && active_source_o == GCSM_SRC_A
            && !switching_o)[*6]
        |-> $stable(active_clock_o))
        else $error("output moved on collapsed input a");
    swing_hold_b_a: assert property (
        (low_swing_hold_b_i && active_source_o == GCSM_SRC_B
            && !switching_o)[*6]
        |-> $stable(active_clock_o))
        else $error("output moved on collapsed input b");
endmodule

bind gcsm_mux gcsm_mux_props props (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .select_i(select_i),
    .low_swing_hold_a_i(low_swing_hold_a_i),
    .low_swing_hold_b_i(low_swing_hold_b_i),
    .active_clock_o(active_clock_o), .active_source_o(active_source_o),
    .switching_o(switching_o),
    .short_cycle_suppressor_on_o(short_cycle_suppressor_on_o));

//--- testbench/gcsm_one_source.sv
// one clock source of the redundant pair, with stuck and collapse modes
`timescale 1ns/1ns

module gcsm_one_source #(
    parameter int HALF = 100
) (
    input wire logic [1:0] mode_i,
    output logic clk_o,
    output logic low_swing_o
);
    logic run = 1'h0;
    logic noise = 1'h0;
    logic dead = 1'h0;
    logic flag = 1'h0;
    logic [1:0] mode_ff = 2'h0;
    always #HALF run = ~run;
    always #7 noise = ~noise;
    // modes change only at own edges, so a mode change never makes a runt
    always @(run) mode_ff = mode_i;
    // the flag trails the last edge by more than a core cycle, so that edge
    // is still taken as valid; the line turns to noise only after the flag
    always @(mode_ff) begin
        flag <= #30 (mode_ff == 2'h1);
        if (mode_ff == 2'h1) begin
            dead <= #60 1'h1;
        end else begin
            dead <= 1'h0;
        end
    end
    assign low_swing_o = flag;
    // modes: 0 running, 1 collapsed, 2 stuck low, 3 stuck high
    assign clk_o = mode_ff == 2'h0 ? run :
        (mode_ff == 2'h1 ? (dead ? noise : run) : mode_ff[0]);
endmodule

//--- testbench/gcsm_mux_test.sv
// self-checking bench for the glitchless clock switchover mux
`timescale 1ns/1ns

module gcsm_mux_test;
    import gcsm_pkg::*;
    // row bits: strap, select, expected suppression, expected level
    logic [3:0] rows [4] = '{4'h3, 4'h6, 4'h9, 4'hC};
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic sel = 1'h0;
    logic strap = 1'h0;
    logic [1:0] mode_a = 2'h3;
    logic [1:0] mode_b = 2'h2;
    logic clk_a, clk_b, low_a, low_b, out, sw, sup, saved;
    gcsm_src_type src;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int low_run;
    always #10 clk = ~clk;
    gcsm_one_source #(.HALF(87)) src_a (.mode_i(mode_a), .clk_o(clk_a),
        .low_swing_o(low_a));
    gcsm_one_source #(.HALF(103)) src_b (.mode_i(mode_b), .clk_o(clk_b),
        .low_swing_o(low_b));
    gcsm_mux dut (.core_clk_i(clk), .sys_rst_i(rst),
        .clock_input_a_i(clk_a), .clock_input_b_i(clk_b), .select_i(sel),
        .startup_delay_cap_pin_i(strap), .low_swing_hold_a_i(low_a),
        .low_swing_hold_b_i(low_b), .active_clock_o(out),
        .active_source_o(src), .switching_o(sw),
        .short_cycle_suppressor_on_o(sup));
    task automatic check(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic restart(input logic s);
        rst = 1'h1;
        strap = s;
        cyc(12);
        check(out, 1'h0);
        check(sw, 1'h0);
        rst = 1'h0;
        cyc(16);
    endtask
    task automatic handover(input logic chk, input logic first);
        int n;
        sel = ~sel;
        for (n = 0; n < 10 && !sw; n++) begin
            cyc(1);
        end
        check(sw, 1'h1);
        if (chk) begin
            check(out, first);
        end
        low_run = 0;
        for (n = 0; n < 147 && sw; n++) begin
            low_run = out ? 0 : low_run + 1;
            cyc(1);
        end
        check(sw, 1'h0);
        check(logic'(src), sel);
        check(low_run >= 6, 1'h1);
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            sel = rows[i][2];
            restart(rows[i][3]);
            check(sup, rows[i][1]);
            check(logic'(src), rows[i][2]);
            check(out, rows[i][0]);
        end
        sel = 1'h0;
        restart(1'h1);
        sel = 1'h1;
        cyc(5);
        check(out, 1'h0);
        check(logic'(src), 1'h1);
        {mode_a, mode_b} = 4'h0;
        sel = 1'h0;
        restart(1'h0);
        handover(1'h0, 1'h0);
        handover(1'h0, 1'h0);
        mode_a = 2'h3;
        cyc(20);
        handover(1'h1, 1'h1);
        {mode_a, mode_b} = 4'h2;
        cyc(20);
        handover(1'h1, 1'h0);
        {mode_a, mode_b} = 4'h4;
        @(posedge low_a);
        saved = clk_a;
        cyc(30);
        check(out, saved);
        handover(1'h1, saved);
        mode_b = 2'h1;
        @(posedge low_b);
        saved = clk_b;
        cyc(30);
        check(out, saved);
        summarize();
    end
endmodule
